// >>> reclose_regs.svh
// register offsets, field positions, reset values and timing counts for the reclose logic
`ifndef RECLOSE_REGS_SVH
`define RECLOSE_REGS_SVH

// register byte offsets
`define CTRL_OFS        8'h00
`define STAT_OFS        8'h04

// control register fields
`define CTRL_W          7
`define CTRL_EN_BIT     0
`define CTRL_MODE_LSB   1
`define CTRL_MODE_MSB   2
`define CTRL_SEQ_LSB    3
`define CTRL_SEQ_MSB    5
`define CTRL_DUAL_BIT   6
`define CTRL_RST        7'h00

// status register fields
`define STAT_W          6
`define STAT_FORCE_BIT  0
`define STAT_MCLS_BIT   1
`define STAT_CLSD_BIT   2
`define STAT_OPEN3_BIT  3
`define STAT_OPEN1_BIT  4
`define STAT_TMR_BIT    5

// bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// shot counter width
`define SHOT_W          3

// timing: clock period, nominal power frequency, 1.25 power cycles rounded up
`define CLK_PERIOD_NS   64'd10
`define POWER_HZ        64'd60
`define SP_DELAY_NS     ((64'd1250000000 + `POWER_HZ - 64'd1) / `POWER_HZ)
`define SP_DELAY_CYC    ((`SP_DELAY_NS + `CLK_PERIOD_NS - 64'd1) / `CLK_PERIOD_NS)
`define TMR_W           24

`endif

// >>> reclose_pkg.sv
// types shared by the reclose terminal logic
package reclose_pkg;
    // operating mode selection
    typedef enum logic [1:0] {
        MODE_1_AND_3P = 2'b00,
        MODE_1P       = 2'b01,
        MODE_3P_A     = 2'b10,
        MODE_3P_B     = 2'b11
    } mode_t;

    // breaker sequence selection
    typedef enum logic [2:0] {
        SEQ_FIRST_ONLY        = 3'b000,
        SEQ_SECOND_ONLY       = 3'b001,
        SEQ_FIRST_THEN_SECOND = 3'b010,
        SEQ_SECOND_THEN_FIRST = 3'b011,
        SEQ_BOTH_TOGETHER     = 3'b100
    } seq_t;

    // delay timer states
    typedef enum logic [1:0] {
        T_IDLE  = 2'b00,
        T_COUNT = 2'b01,
        T_DONE  = 2'b10
    } tstate_t;
endpackage

// >>> timer_if.sv
// control and result signals between the reclose logic and its delay timer
interface timer_if;
    logic run;
    logic hold;
    logic done;

    modport ctl (output run, output hold, input done);
    modport tmr (input run, input hold, output done);
endinterface

// >>> sp_delay_timer.sv
// delay timer for the single-pole initiate, freezable by pause
`include "reclose_regs.svh"
module sp_delay_timer
    import reclose_pkg::*;
#(
    parameter logic [`TMR_W-1:0] P_CYC = 24'h000001
) (
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst,
    // timer control
    timer_if.tmr      t
);
    tstate_t           state_r;
    tstate_t           state_nxt;
    logic [`TMR_W-1:0] cnt_r;
    logic [`TMR_W-1:0] cnt_nxt;
    logic              cnt_last;

    assign cnt_last = (cnt_r == P_CYC - 24'h000001);
    assign t.done   = (state_r == T_DONE);

    // next state: count only while running and not paused
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            T_IDLE: begin
                cnt_nxt = 24'h000000;
                if (t.run) begin
                    state_nxt = T_COUNT;
                end
            end
            T_COUNT: begin
                if (!t.run) begin
                    state_nxt = T_IDLE;
                end else if (!t.hold) begin
                    if (cnt_last) begin
                        state_nxt = T_DONE;
                    end else begin
                        cnt_nxt = cnt_r + 24'h000001;
                    end
                end
            end
            T_DONE: begin
                if (!t.run) begin
                    state_nxt = T_IDLE;
                end
            end
            default: begin
                state_nxt = T_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= T_IDLE;
            cnt_r   <= 24'h000000;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // pause freezes the elapsed count
    hold_freeze_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (state_r == T_COUNT && t.run && t.hold) |=> (cnt_r == $past(cnt_r)))
        else $error("timer moved while paused");

    // done only follows a running request
    done_cause_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        $rose(t.done) |-> $past(t.run) && $past(cnt_last))
        else $error("timer done without full count");

    timer_done_c: cover property (@(posedge i_mclk) disable iff (i_rst) $rose(t.done));
endmodule

// >>> reclose_terminal.sv
// reclose terminal status logic with force three-pole trip and AXI4-Lite registers
// Summary of operation
// - Force three-pole trip while the scheme is paused, also after initiation.
// - Force three-pole trip while the scheme is in lockout.
// - Force three-pole trip when mode is three-pole variant A or B.
// - Force three-pole trip while the shot count is not zero.
// - Force three-pole trip once 1.25 power cycles follow single-pole initiate.
// - Manual close from first breaker, second-only not selected, second open or out.
// - Manual close from second breaker, first-only not selected, first open or out.
// - Each terminal output except force three-pole trip is also asserted by its own override input.
// - Single breaker: terminal closed follows that breaker's closed status.
// - Dual breaker: closed when some breaker is closed and in service.
// - Single breaker: three-pole open follows that breaker's open status.
// - Dual breaker: three-pole open when each breaker is open or out of service.
// - Bus fault initiate: three-pole open when either breaker is open.
// - Single breaker: one-pole open follows the selected breaker's one-pole flag.
// - Both together: each breaker one-pole open, open or out of service.
// - First then second: first one-pole open, second one-pole open or out.
// - Second then first: second one-pole open, first one-pole, open or out.
// - An enable bit switches the scheme on or off, off after reset.
// - Pause freezes the delay progress and resumes from the same point.
// - Four operating modes are accepted and steer the trip request.
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`include "reclose_regs.svh"
module reclose_terminal
    import reclose_pkg::*;
#(
    parameter logic [`TMR_W-1:0] P_SP_DELAY_CYC = `TMR_W'(`SP_DELAY_CYC)
) (
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    // AXI4-Lite write address and data
    input  wire logic              i_s_axi_awvalid,
    output logic                   o_s_axi_awready,
    input  wire logic [7:0]        i_s_axi_awaddr,
    input  wire logic              i_s_axi_wvalid,
    output logic                   o_s_axi_wready,
    input  wire logic [31:0]       i_s_axi_wdata,
    input  wire logic [3:0]        i_s_axi_wstrb,
    // AXI4-Lite write response
    output logic                   o_s_axi_bvalid,
    input  wire logic              i_s_axi_bready,
    output logic [1:0]             o_s_axi_bresp,
    // AXI4-Lite read
    input  wire logic              i_s_axi_arvalid,
    output logic                   o_s_axi_arready,
    input  wire logic [7:0]        i_s_axi_araddr,
    output logic                   o_s_axi_rvalid,
    input  wire logic              i_s_axi_rready,
    output logic [31:0]            o_s_axi_rdata,
    output logic [1:0]             o_s_axi_rresp,
    // scheme state from the reclose sequencer
    input  wire logic              i_pause,
    input  wire logic              i_lockout,
    input  wire logic [`SHOT_W-1:0] i_shot_count,
    input  wire logic              i_single_pole_reclose_initiate,
    input  wire logic              i_bus_fault_initiate,
    // first breaker status
    input  wire logic              i_first_breaker_closed,
    input  wire logic              i_first_breaker_open,
    input  wire logic              i_first_breaker_out_of_service,
    input  wire logic              i_first_breaker_manual_close,
    input  wire logic              i_first_breaker_one_pole_open,
    // second breaker status
    input  wire logic              i_second_breaker_closed,
    input  wire logic              i_second_breaker_open,
    input  wire logic              i_second_breaker_out_of_service,
    input  wire logic              i_second_breaker_manual_close,
    input  wire logic              i_second_breaker_one_pole_open,
    // user overrides
    input  wire logic              i_ovr_manual_close,
    input  wire logic              i_ovr_closed,
    input  wire logic              i_ovr_three_pole_open,
    input  wire logic              i_ovr_one_pole_open,
    // terminal outputs
    output logic                   o_force_three_pole_trip,
    output logic                   o_terminal_manual_close,
    output logic                   o_terminal_closed,
    output logic                   o_terminal_three_pole_open,
    output logic                   o_terminal_one_pole_open
);
    logic [`CTRL_W-1:0] ctrl_r;
    logic [`CTRL_W-1:0] ctrl_nxt;
    logic               aw_got_r;
    logic               w_got_r;
    logic [7:0]         awaddr_r;
    logic [31:0]        wdata_r;
    logic [3:0]         wstrb_r;
    logic               aw_hs;
    logic               w_hs;
    logic               b_hs;
    logic               ar_hs;
    logic               r_hs;
    logic               wr_do;
    logic               wr_ctrl;
    logic               wr_bad;
    logic               rd_ctrl;
    logic               rd_stat;
    logic [31:0]        rd_data;
    logic               en;
    mode_t              mode;
    seq_t               seq;
    logic               dual;
    logic               use_second;
    logic               b1_out;
    logic               b2_out;
    logic               mode_3p;
    logic               shot_nz;
    logic               force_nxt;
    logic               mcls_nxt;
    logic               clsd_nxt;
    logic               open3_nxt;
    logic               open1_nxt;
    logic               clsd_raw;
    logic               open3_raw;
    logic               open1_raw;
    logic               mcls_raw;
    timer_if            tmr ();

    // bus handshakes
    assign aw_hs   = i_s_axi_awvalid & o_s_axi_awready;
    assign w_hs    = i_s_axi_wvalid & o_s_axi_wready;
    assign b_hs    = o_s_axi_bvalid & i_s_axi_bready;
    assign ar_hs   = i_s_axi_arvalid & o_s_axi_arready;
    assign r_hs    = o_s_axi_rvalid & i_s_axi_rready;

    // write decode once both halves are held
    assign wr_do   = aw_got_r & w_got_r & ~o_s_axi_bvalid;
    assign wr_ctrl = wr_do & (awaddr_r == `CTRL_OFS) & wstrb_r[0];
    assign wr_bad  = (awaddr_r != `CTRL_OFS);
    assign ctrl_nxt = wr_ctrl ? wdata_r[`CTRL_W-1:0] : ctrl_r;

    // read decode; reserved bits read zero
    assign rd_ctrl = (i_s_axi_araddr == `CTRL_OFS);
    assign rd_stat = (i_s_axi_araddr == `STAT_OFS);
    assign rd_data = rd_ctrl ? {25'h0000000, ctrl_r} :
                     rd_stat ? {26'h0000000, tmr.done, o_terminal_one_pole_open,
                                o_terminal_three_pole_open, o_terminal_closed,
                                o_terminal_manual_close, o_force_three_pole_trip} :
                               32'h00000000;

    // write channel registers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_s_axi_awready <= 1'h1;
            o_s_axi_wready  <= 1'h1;
            aw_got_r        <= 1'h0;
            w_got_r         <= 1'h0;
            awaddr_r        <= 8'h00;
            wdata_r         <= 32'h00000000;
            wstrb_r         <= 4'h0;
            o_s_axi_bvalid  <= 1'h0;
            o_s_axi_bresp   <= `RESP_OKAY;
        end else begin
            if (aw_hs) begin
                awaddr_r        <= i_s_axi_awaddr;
                aw_got_r        <= 1'h1;
                o_s_axi_awready <= 1'h0;
            end
            if (w_hs) begin
                wdata_r        <= i_s_axi_wdata;
                wstrb_r        <= i_s_axi_wstrb;
                w_got_r        <= 1'h1;
                o_s_axi_wready <= 1'h0;
            end
            if (wr_do) begin
                o_s_axi_bvalid <= 1'h1;
                o_s_axi_bresp  <= wr_bad ? `RESP_SLVERR : `RESP_OKAY;
                aw_got_r       <= 1'h0;
                w_got_r        <= 1'h0;
            end
            if (b_hs) begin
                o_s_axi_bvalid  <= 1'h0;
                o_s_axi_awready <= 1'h1;
                o_s_axi_wready  <= 1'h1;
            end
        end
    end

    // read channel registers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_s_axi_arready <= 1'h1;
            o_s_axi_rvalid  <= 1'h0;
            o_s_axi_rdata   <= 32'h00000000;
            o_s_axi_rresp   <= `RESP_OKAY;
        end else if (ar_hs) begin
            o_s_axi_arready <= 1'h0;
            o_s_axi_rvalid  <= 1'h1;
            o_s_axi_rdata   <= rd_data;
            o_s_axi_rresp   <= (rd_ctrl | rd_stat) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (r_hs) begin
            o_s_axi_arready <= 1'h1;
            o_s_axi_rvalid  <= 1'h0;
        end
    end

    // control register, disabled after reset
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_r <= `CTRL_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // control fields
    assign en         = ctrl_r[`CTRL_EN_BIT];
    assign mode       = mode_t'(ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
    assign seq        = seq_t'(ctrl_r[`CTRL_SEQ_MSB:`CTRL_SEQ_LSB]);
    assign dual       = ctrl_r[`CTRL_DUAL_BIT];
    assign use_second = (seq == SEQ_SECOND_ONLY);
    assign b1_out     = i_first_breaker_open | i_first_breaker_out_of_service;
    assign b2_out     = i_second_breaker_open | i_second_breaker_out_of_service;

    // single-pole delay, frozen while paused
    assign tmr.run  = en & i_single_pole_reclose_initiate;
    assign tmr.hold = i_pause;

    sp_delay_timer #(
        .P_CYC (P_SP_DELAY_CYC)
    ) u_delay (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .t      (tmr)
    );

    // force three-pole trip request
    assign mode_3p   = (mode == MODE_3P_A) | (mode == MODE_3P_B);
    assign shot_nz   = (i_shot_count != `SHOT_W'(0));
    assign force_nxt = en & (i_pause | i_lockout | mode_3p | shot_nz | tmr.done);

    // terminal manual close
    assign mcls_raw = (i_first_breaker_manual_close & (seq != SEQ_SECOND_ONLY) & b2_out)
                    | (i_second_breaker_manual_close & (seq != SEQ_FIRST_ONLY) & b1_out);

    // terminal closed
    assign clsd_raw = dual ? ((i_first_breaker_closed & ~i_first_breaker_out_of_service)
                            | (i_second_breaker_closed & ~i_second_breaker_out_of_service))
                           : (use_second ? i_second_breaker_closed : i_first_breaker_closed);

    // terminal three-pole open
    assign open3_raw = i_bus_fault_initiate ? (i_first_breaker_open | i_second_breaker_open)
                     : dual ? (b1_out & b2_out)
                     : (use_second ? i_second_breaker_open : i_first_breaker_open);

    // terminal one-pole open per sequence
    always_comb begin
        open1_raw = 1'h0;
        if (!dual) begin
            open1_raw = use_second ? i_second_breaker_one_pole_open
                                   : i_first_breaker_one_pole_open;
        end else begin
            case (seq)
                SEQ_BOTH_TOGETHER: begin
                    open1_raw = (i_first_breaker_one_pole_open | b1_out)
                              & (i_second_breaker_one_pole_open | b2_out);
                end
                SEQ_FIRST_THEN_SECOND: begin
                    open1_raw = i_first_breaker_one_pole_open
                              & (i_second_breaker_one_pole_open
                                 | i_second_breaker_out_of_service);
                end
                SEQ_SECOND_THEN_FIRST: begin
                    open1_raw = i_second_breaker_one_pole_open
                              & (i_first_breaker_one_pole_open | b1_out);
                end
                SEQ_SECOND_ONLY: begin
                    open1_raw = i_second_breaker_one_pole_open;
                end
                default: begin
                    open1_raw = i_first_breaker_one_pole_open;
                end
            endcase
        end
    end

    // gate by enable, then add overrides
    assign mcls_nxt  = (en & mcls_raw) | i_ovr_manual_close;
    assign clsd_nxt  = (en & clsd_raw) | i_ovr_closed;
    assign open3_nxt = (en & open3_raw) | i_ovr_three_pole_open;
    assign open1_nxt = (en & open1_raw) | i_ovr_one_pole_open;

    // terminal outputs, one evaluation per clock
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_force_three_pole_trip    <= 1'h0;
            o_terminal_manual_close    <= 1'h0;
            o_terminal_closed          <= 1'h0;
            o_terminal_three_pole_open <= 1'h0;
            o_terminal_one_pole_open   <= 1'h0;
        end else begin
            o_force_three_pole_trip    <= force_nxt;
            o_terminal_manual_close    <= mcls_nxt;
            o_terminal_closed          <= clsd_nxt;
            o_terminal_three_pole_open <= open3_nxt;
            o_terminal_one_pole_open   <= open1_nxt;
        end
    end

    // checks
    pause_force_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (en && i_pause) |=> o_force_three_pole_trip)
        else $error("pause did not force three-pole trip");

    lockout_force_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (en && i_lockout) |=> o_force_three_pole_trip)
        else $error("lockout did not force three-pole trip");

    mode_force_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (en && (mode == MODE_3P_A || mode == MODE_3P_B)) |=> o_force_three_pole_trip)
        else $error("three-pole mode did not force trip");

    shot_force_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (en && i_shot_count != `SHOT_W'(0)) |=> o_force_three_pole_trip)
        else $error("nonzero shot count did not force trip");

    delay_force_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (en && !i_pause && !i_lockout && !mode_3p && !shot_nz
         && !i_single_pole_reclose_initiate) |=> !o_force_three_pole_trip)
        else $error("trip forced without cause");

    man_close_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (en && i_first_breaker_manual_close && seq != SEQ_SECOND_ONLY && b2_out)
        |=> o_terminal_manual_close)
        else $error("first breaker manual close not declared");

    closed_dual_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (en && dual && !i_ovr_closed && i_first_breaker_closed
         && i_first_breaker_out_of_service && !i_second_breaker_closed)
        |=> !o_terminal_closed)
        else $error("out-of-service breaker reported terminal closed");

    bus_fault_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (en && i_bus_fault_initiate && (i_first_breaker_open || i_second_breaker_open))
        |=> o_terminal_three_pole_open)
        else $error("bus fault open not declared");

    seq_21_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (en && dual && seq == SEQ_SECOND_THEN_FIRST && !i_ovr_one_pole_open
         && !i_second_breaker_one_pole_open) |=> !o_terminal_one_pole_open)
        else $error("one-pole open without second breaker flag");

    disabled_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (!en && !i_ovr_closed) ##1 !$past(en) |-> !o_force_three_pole_trip && !o_terminal_closed)
        else $error("disabled scheme drove outputs");

    override_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_ovr_three_pole_open |=> o_terminal_three_pole_open)
        else $error("override ignored");

    bresp_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        wr_do |=> o_s_axi_bvalid)
        else $error("write response missing");

    // main scenarios
    force_delay_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        tmr.done ##1 o_force_three_pole_trip);
    one_pole_both_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        dual && seq == SEQ_BOTH_TOGETHER && o_terminal_one_pole_open);
    ctrl_write_c: cover property (@(posedge i_mclk) disable iff (i_rst) wr_ctrl);
endmodule

// >>> breaker_model.sv
// breaker status side model feeding the reclose terminal logic
module breaker_model (
    // clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    // commanded breaker states
    input  wire logic [9:0] i_cmd,
    // breaker status toward the terminal logic
    output logic [9:0]      o_status
);
    timeunit 1ns;
    timeprecision 1ps;
    // auxiliary contacts report one pass after the command
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) o_status <= 10'h000;
        else o_status <= i_cmd;
    end
endmodule

// >>> reclose_terminal_tb_top.sv
// self-checking bench for the reclose terminal logic and its register port
`include "reclose_regs.svh"
module reclose_terminal_tb_top;
    import reclose_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [6:0] c; logic [9:0] b; logic [7:0] m; logic [4:0] e;} row_t;
    logic i_mclk = 0, i_rst = 1, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
    logic i_s_axi_arvalid = 0, i_s_axi_rready = 0, i_pause = 0, i_lockout = 0;
    logic i_single_pole_reclose_initiate = 0, i_bus_fault_initiate = 0;
    logic i_ovr_manual_close = 0, i_ovr_closed = 0, i_ovr_three_pole_open = 0;
    logic i_ovr_one_pole_open = 0, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
    logic o_s_axi_arready, o_s_axi_rvalid, o_force_three_pole_trip, o_terminal_manual_close;
    logic o_terminal_closed, o_terminal_three_pole_open, o_terminal_one_pole_open;
    logic i_first_breaker_closed, i_first_breaker_open, i_first_breaker_out_of_service;
    logic i_first_breaker_manual_close, i_first_breaker_one_pole_open, i_second_breaker_closed;
    logic i_second_breaker_open, i_second_breaker_out_of_service, i_second_breaker_manual_close;
    logic i_second_breaker_one_pole_open;
    logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
    logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, rd;
    logic [3:0]  i_s_axi_wstrb = 4'hF;
    logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, rsp;
    logic [2:0]  i_shot_count = 3'h0;
    logic [9:0]  cmd = 10'h000, brk;
    int          fails = 0, check_count = 0, cyc = 0;
    wire  [31:0] outs = {27'h0, o_force_three_pole_trip, o_terminal_manual_close,
                         o_terminal_closed, o_terminal_three_pole_open, o_terminal_one_pole_open};
    // ctrl, breakers, pause/lockout/shot/busfault/overrides, expected outputs
    row_t rows [23] = '{
        '{7'h00,10'h000,8'h80,5'h00}, '{7'h01,10'h000,8'h80,5'h10}, '{7'h01,10'h000,8'h40,5'h10},
        '{7'h01,10'h000,8'h20,5'h10}, '{7'h05,10'h000,8'h00,5'h10}, '{7'h07,10'h000,8'h00,5'h10},
        '{7'h03,10'h000,8'h00,5'h00}, '{7'h01,10'h200,8'h00,5'h04}, '{7'h01,10'h100,8'h00,5'h02},
        '{7'h09,10'h201,8'h00,5'h01}, '{7'h01,10'h048,8'h00,5'h08}, '{7'h09,10'h048,8'h00,5'h02},
        '{7'h09,10'h082,8'h00,5'h08}, '{7'h41,10'h280,8'h00,5'h00}, '{7'h41,10'h290,8'h00,5'h04},
        '{7'h41,10'h104,8'h00,5'h02}, '{7'h41,10'h100,8'h00,5'h00}, '{7'h41,10'h100,8'h10,5'h02},
        '{7'h61,10'h028,8'h00,5'h01}, '{7'h51,10'h024,8'h00,5'h01}, '{7'h51,10'h028,8'h00,5'h00},
        '{7'h59,10'h101,8'h00,5'h01}, '{7'h00,10'h000,8'h0F,5'h0F}};

    reclose_terminal #(.P_SP_DELAY_CYC(24'h000008)) DUT (.*);
    breaker_model partner (.i_mclk(i_mclk), .i_rst(i_rst), .i_cmd(cmd), .o_status(brk));
    assign {i_first_breaker_closed, i_first_breaker_open, i_first_breaker_out_of_service,
            i_first_breaker_manual_close, i_first_breaker_one_pole_open, i_second_breaker_closed,
            i_second_breaker_open, i_second_breaker_out_of_service, i_second_breaker_manual_close,
            i_second_breaker_one_pole_open} = brk;

    always #5 i_mclk = ~i_mclk;
    // hang guard
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        i_s_axi_awaddr  <= a;
        i_s_axi_wdata   <= d;
        i_s_axi_wstrb   <= s;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid  <= 1'b1;
        i_s_axi_bready  <= 1'b1;
        do begin
            @(posedge i_mclk);
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
        end while (!o_s_axi_bvalid);
        i_s_axi_bready <= 1'b0;
        rsp = o_s_axi_bresp;
        @(posedge i_mclk);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        i_s_axi_araddr  <= a;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready  <= 1'b1;
        do begin
            @(posedge i_mclk);
            if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
        end while (!o_s_axi_rvalid);
        i_s_axi_rready <= 1'b0;
        rd  = o_s_axi_rdata;
        rsp = o_s_axi_rresp;
        @(posedge i_mclk);
    endtask
    // breaker status passes the model, then the terminal logic
    task automatic apply(input row_t r);
        cmd <= r.b;
        {i_pause, i_lockout, i_shot_count[0], i_bus_fault_initiate} <= r.m[7:4];
        {i_ovr_manual_close, i_ovr_closed, i_ovr_three_pole_open, i_ovr_one_pole_open} <= r.m[3:0];
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask

    initial begin
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        axi_rd(`CTRL_OFS);
        check(rd, 32'h00000000);
        axi_wr(8'h08, 32'h00000001, 4'hF);
        check({30'h0, rsp}, {30'h0, `RESP_SLVERR});
        axi_rd(8'h08);
        check({30'h0, rsp}, {30'h0, `RESP_SLVERR});
        axi_wr(`CTRL_OFS, 32'h00000001, 4'h0);
        axi_rd(`CTRL_OFS);
        check(rd, 32'h00000000);
        $display("register port test done");
        foreach (rows[i]) begin
            @(posedge i_mclk);
            axi_wr(`CTRL_OFS, {25'h0, rows[i].c}, 4'hF);
            apply(rows[i]);
            check(outs, {27'h0, rows[i].e});
        end
        $display("terminal table test done");
        apply('0);
        @(posedge i_mclk);
        axi_wr(`CTRL_OFS, 32'h00000001, 4'hF);
        i_single_pole_reclose_initiate <= 1'b1;
        // pause for ten passes mid-count; count resumes where it stopped
        for (int k = 1; k <= 20; k++) begin
            @(posedge i_mclk);
            i_pause <= (k >= 2 && k <= 11);
            @(negedge i_mclk);
            if (k >= 19) check(outs, {27'h0, k == 20, 4'h0});
        end
        @(posedge i_mclk);
        axi_rd(`STAT_OFS);
        check(rd, 32'h00000021);
        $display("delay timer test done");
        complete_run();
    end
endmodule
